// ===== cpu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_mem_model (
   input wire logic i_ref_clk,
   input wire logic i_req,
   input wire logic [23:0] i_addr,
   output logic [31:0] o_data,
   output logic o_valid = 1'b0
);
   // Junk top byte: the core must drop it; released bus shows inverse
   always @(posedge i_ref_clk) begin
      o_valid <= i_req;
      o_data <= i_req ? {8'hff, 8'h5a, i_addr[7:0], 8'h3c} : ~o_data;
   end
endmodule
`default_nettype wire

// ===== cpu_mode_address_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_mode_consts.svh"
module cpu_mode_address_logic (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Mode pins
   input wire logic [1:0] i_mode_pins,
   // Address generation
   input wire logic [23:0] i_ea_raw,
   input wire logic [23:0] i_program_counter,
   input wire cpu_mode_pkg::ptr_req_t i_ptr,
   // Vector and memory indirect operand
   input wire logic [7:0] i_vec_num,
   input wire logic [7:0] i_ind_addr,
   input wire logic [31:0] i_ind_operand,
   input wire logic i_ind_valid,
   // Exception entry
   input wire logic i_call,
   input wire logic i_exc,
   input wire logic [1:0] i_int_ctrl_mode,
   input wire logic i_ext_reg_valid,
   // Execution timing
   input wire logic i_op_start,
   input wire cpu_mode_pkg::alu_op_t i_op,
   // Outputs
   output logic o_mode_adv,
   output logic o_mode_err,
   output logic [23:0] o_effective_address,
   output logic [23:0] o_fetch_addr,
   output logic [31:0] o_ptr_next,
   output logic [23:0] o_vec_addr,
   output logic [23:0] o_ind_ptr_addr,
   output logic [23:0] o_branch_target,
   output logic [2:0] o_push_mask,
   output logic o_busy,
   output logic o_done
);
   import cpu_mode_pkg::*;
   core_state_t s_q;
   core_state_t s_d;
   logic [4:0] op_states;
   logic [31:0] step32;
   logic mode_req_adv;

   // Decoded continuously; pins still drive o_mode_err after capture
   assign mode_req_adv = (i_mode_pins == `MODE_PIN_ADV); // [R1]

   always_comb begin
      unique case (i_op)
         OP_ADDSUB: op_states = `ST_ADDSUB; // [R15]
         OP_MULU_B: op_states = `ST_MULU_B; // [R16]
         OP_MULU_W: op_states = `ST_MULU_W; // [R16]
         OP_MULS_B: op_states = `ST_MULS_B; // [R18]
         OP_MULS_W: op_states = `ST_MULS_W; // [R18]
         OP_DIV_B: op_states = `ST_DIV_B; // [R17]
         OP_DIV_W: op_states = `ST_DIV_W; // [R17]
         OP_NONE: op_states = 5'h00;
      endcase
   end

   always_comb begin
      s_d = s_q;
      step32 = {29'h0000_0000, i_ptr.step};
      s_d.done = 1'b0;
      // Set advanced mode, whatever the pins, on the first edge after release, then freeze it
      if (!s_q.mode_valid) begin
         s_d.mode_valid = 1'b1; // [R20]
         s_d.mode_adv = 1'b1; // [R2]
      end
      // Full 32-bit add so carries reach the upper half in any mode
      if (i_ptr.inc) begin
         s_d.ptr = i_ptr.wide_general_register + step32; // [R5] [R10]
      end else if (i_ptr.dec) begin
         s_d.ptr = i_ptr.wide_general_register - step32; // [R5] [R10]
      end else begin
         s_d.ptr = i_ptr.wide_general_register; // [R10]
      end
      // Next-state mode, so the first edge after reset already decodes advanced
      if (s_d.mode_adv) begin
         s_d.effective_address = i_ea_raw; // [R9]
         s_d.vec_addr = `VEC_BASE + {14'h0000, i_vec_num, 2'h0}; // [R11]
         s_d.branch_target = {i_ind_operand[23:0]}; // [R11] [R12]
      end else begin
         s_d.effective_address = i_ea_raw & `SMALL_ADDR_MASK; // [R3] [R4]
         s_d.vec_addr = `VEC_BASE + {15'h0000, i_vec_num, 1'h0}; // [R6]
         s_d.branch_target = {8'h00, i_ind_operand[15:0]}; // [R7]
      end
      if (!i_ind_valid) begin
         s_d.branch_target = s_q.branch_target;
      end
      s_d.fetch_addr = {i_program_counter[23:1], 1'b0}; // [R19]
      // Bit 0 counter, bit 1 flags, bit 2 extended register
      if (i_exc) begin
         s_d.push_mask = {i_ext_reg_valid && (i_int_ctrl_mode != 2'h0), 2'h3}; // [R8] [R13] [R14]
      end else if (i_call) begin
         s_d.push_mask = 3'h1; // [R14]
      end else begin
         s_d.push_mask = 3'h0;
      end
      unique case (s_q.state)
         ST_IDLE: begin
            if (i_op_start && op_states != 5'h00) begin
               if (op_states == 5'h01) begin
                  s_d.done = 1'b1; // [R15]
               end else begin
                  s_d.count = op_states - 5'h01;
                  s_d.state = ST_BUSY;
               end
            end
         end
         ST_BUSY: begin
            s_d.count = s_q.count - 5'h01;
            if (s_q.count == 5'h01) begin
               s_d.done = 1'b1; // [R16] [R17] [R18]
               s_d.state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_mode_adv = s_q.mode_adv;
   // Flags a strap requesting the unsupported mode; the core still runs advanced
   assign o_mode_err = s_q.mode_valid && !mode_req_adv; // [R2]
   assign o_effective_address = s_q.effective_address;
   assign o_fetch_addr = s_q.fetch_addr;
   assign o_ptr_next = s_q.ptr;
   assign o_vec_addr = s_q.vec_addr;
   assign o_ind_ptr_addr = {16'h0000, i_ind_addr}; // [R7] [R12]
   assign o_branch_target = s_q.branch_target;
   assign o_push_mask = s_q.push_mask;
   assign o_busy = (s_q.state == ST_BUSY);
   assign o_done = s_q.done;
endmodule
`default_nettype wire

// ===== cpu_mode_address_logic_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_address_checker
   import cpu_mode_pkg::*;
(
   input wire logic i_ref_clk, i_rst, i_ind_valid, i_exc, i_ext_reg_valid, i_op_start,
   input wire logic [23:0] i_ea_raw, i_program_counter,
   input wire ptr_req_t i_ptr,
   input wire logic [7:0] i_vec_num,
   input wire logic [31:0] i_ind_operand, o_ptr_next,
   input wire logic [1:0] i_int_ctrl_mode,
   input wire alu_op_t i_op,
   input wire logic o_mode_adv, o_busy, o_done,
   input wire logic [23:0] o_effective_address, o_fetch_addr, o_vec_addr, o_branch_target,
   input wire logic [2:0] o_push_mask
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   a_mode_fixed: assert property (!i_rst |=> o_mode_adv)
      else $error("mode lost");
   a_ea_full: assert property (!i_rst |=> o_effective_address == $past(i_ea_raw))
      else $error("ea wrong");
   a_fetch_even: assert property (!i_rst |=> o_fetch_addr == {$past(i_program_counter[23:1]), 1'b0})
      else $error("fetch odd");
   a_ptr_carry: assert property (i_ptr.inc |=> o_ptr_next == $past(i_ptr.wide_general_register) + $past(i_ptr.step))
      else $error("ptr wrong");
   a_vec_long: assert property (!i_rst |=> o_vec_addr == {14'h0000, $past(i_vec_num), 2'h0})
      else $error("vec wrong");
   a_ind_low: assert property (i_ind_valid |=> o_branch_target == $past(i_ind_operand[23:0]))
      else $error("target wrong");
   a_push_exc: assert property (i_exc |=> o_push_mask == {$past(i_ext_reg_valid) && $past(i_int_ctrl_mode) != 2'h0, 2'h3})
      else $error("push wrong");
   a_mul_time: assert property (i_op_start && !o_busy && i_op == OP_MULU_B |=> o_busy [*2] ##1 o_done && !o_busy)
      else $error("mul time");
endmodule
bind cpu_mode_address_logic cpu_mode_address_checker u_checker (.i_ref_clk, .i_rst, .i_ind_valid, .i_exc,
   .i_ext_reg_valid, .i_op_start, .i_ea_raw, .i_program_counter, .i_ptr, .i_vec_num, .i_ind_operand,
   .o_ptr_next, .i_int_ctrl_mode, .i_op, .o_mode_adv, .o_busy, .o_done, .o_effective_address,
   .o_fetch_addr, .o_vec_addr, .o_branch_target, .o_push_mask);
`default_nettype wire

// ===== cpu_mode_address_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_address_logic_tb;
   import cpu_mode_pkg::*;
   logic i_ref_clk = 1'b0, i_rst = 1'b1, i_call = 1'b0, i_exc = 1'b0, i_ind_valid, req = 1'b0;
   logic i_ext_reg_valid = 1'b0, i_op_start = 1'b0, o_mode_adv, o_mode_err, o_busy, o_done;
   logic [1:0] i_mode_pins = 2'h1, i_int_ctrl_mode = 2'h0;
   logic [23:0] i_ea_raw = 24'h00_0000, i_program_counter = 24'h00_0000, o_ind_ptr_addr;
   logic [23:0] o_effective_address, o_fetch_addr, o_vec_addr, o_branch_target;
   logic [7:0] i_vec_num = 8'h00, i_ind_addr = 8'h00;
   logic [31:0] i_ind_operand, o_ptr_next;
   logic [2:0] o_push_mask;
   ptr_req_t i_ptr = '0;
   alu_op_t i_op = OP_NONE;
   int num_errors = 0, checked = 0, cycles = 0, n;
   int lat[7] = '{1, 3, 4, 4, 5, 12, 20};
   cpu_mode_address_logic u_cpu_mode_address_logic (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
      .i_mode_pins(i_mode_pins), .i_ea_raw(i_ea_raw), .i_program_counter(i_program_counter),
      .i_ptr(i_ptr), .i_vec_num(i_vec_num), .i_ind_addr(i_ind_addr),
      .i_ind_operand(i_ind_operand), .i_ind_valid(i_ind_valid), .i_call(i_call), .i_exc(i_exc),
      .i_int_ctrl_mode(i_int_ctrl_mode), .i_ext_reg_valid(i_ext_reg_valid),
      .i_op_start(i_op_start), .i_op(i_op), .o_mode_adv(o_mode_adv), .o_mode_err(o_mode_err),
      .o_effective_address(o_effective_address), .o_fetch_addr(o_fetch_addr),
      .o_ptr_next(o_ptr_next), .o_vec_addr(o_vec_addr), .o_ind_ptr_addr(o_ind_ptr_addr),
      .o_branch_target(o_branch_target), .o_push_mask(o_push_mask), .o_busy(o_busy),
      .o_done(o_done));
   cpu_mem_model u_cpu_mem_model (.i_ref_clk(i_ref_clk), .i_req(req), .i_addr(o_ind_ptr_addr),
      .o_data(i_ind_operand), .o_valid(i_ind_valid));
   initial forever #5 i_ref_clk = ~i_ref_clk;
   // Whole run is under 200 cycles
   always @(posedge i_ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         num_errors++;
         give_verdict;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task nx;
      @(posedge i_ref_clk);
      @(negedge i_ref_clk);
   endtask
   task give_verdict;
      $display("checked=%0d errors=%0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task t_addr;
      @(posedge i_ref_clk);
      i_mode_pins <= 2'h0;
      i_ea_raw <= 24'hff_ffff;
      i_program_counter <= 24'h12_3457;
      i_vec_num <= 8'hff;
      nx;
      chk(o_mode_adv, 1'b1);
      chk(o_mode_err, 1'b1);
      chk(o_effective_address, 24'hff_ffff);
      chk(o_fetch_addr, 24'h12_3456);
      chk(o_vec_addr, 24'h00_03fc);
      $display("addr end");
   endtask
   task t_ptr;
      @(posedge i_ref_clk);
      i_ptr <= '{32'h0000_ffff, 1'b1, 1'b0, 3'h1};
      nx;
      chk(o_ptr_next, 32'h0001_0000);
      @(posedge i_ref_clk);
      i_ptr <= '{32'h0001_0000, 1'b0, 1'b1, 3'h2};
      nx;
      chk(o_ptr_next, 32'h0000_fffe);
      $display("ptr end");
   endtask
   task t_ind;
      @(posedge i_ref_clk);
      i_ind_addr <= 8'h80;
      req <= 1'b1;
      @(posedge i_ref_clk);
      req <= 1'b0;
      nx;
      chk(o_ind_ptr_addr, 24'h00_0080);
      chk(o_branch_target, 24'h5a_803c);
      $display("ind end");
   endtask
   task t_push;
      for (int k = 0; k < 4; k++) begin
         @(posedge i_ref_clk);
         i_call <= (k == 0);
         i_exc <= (k != 0);
         i_int_ctrl_mode <= (k == 3) ? 2'h0 : 2'h2;
         i_ext_reg_valid <= (k != 2);
         nx;
         chk(o_push_mask, k == 1 ? 3'h7 : k == 0 ? 3'h1 : 3'h3);
      end
      @(posedge i_ref_clk);
      i_exc <= 1'b0;
      $display("push end");
   endtask
   task t_ops;
      for (int k = 0; k < 7; k++) begin
         @(posedge i_ref_clk);
         i_op <= alu_op_t'(k);
         i_op_start <= 1'b1;
         @(posedge i_ref_clk);
         i_op_start <= 1'b0;
         n = 0;
         do begin
            @(negedge i_ref_clk);
            n++;
         end while (o_done !== 1'b1 && n < 30);
         chk(n, lat[k]);
         chk(o_busy, 1'b0);
      end
      @(posedge i_ref_clk);
      i_op <= OP_NONE;
      i_op_start <= 1'b1;
      nx;
      chk(o_done, 1'b0);
      chk(o_busy, 1'b0);
      @(posedge i_ref_clk);
      i_op_start <= 1'b0;
      $display("ops end");
   endtask
   initial begin
      repeat (10) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      t_addr;
      t_ptr;
      t_ind;
      t_push;
      t_ops;
      give_verdict;
   end
endmodule
`default_nettype wire

// ===== cpu_mode_consts.svh
// How it works
// [R1] Operating mode comes from the mode pins, never from software.
// [R2] Only advanced mode exists; small-address mode cannot be selected.
// [R3] Small-address mode would limit reach to 64 kbytes.
// [R4] Small-address mode would keep only the low 16 address bits.
// [R5] Pointer increment or decrement carry always propagates into the upper half.
// [R6] Small-address vector table starts at zero with 16-bit entries.
// [R7] Small-address indirect branch fetches a 16-bit word from 0 to 0xFF.
// [R8] Interrupt control mode 0 never stacks the extended control register.
// [R9] Advanced mode gives linear access to 16 Mbytes.
// [R10] Upper halves work alone or as the top of 32-bit registers.
// [R11] Advanced vectors are 32-bit; top 8 bits are ignored.
// [R12] Advanced indirect branch fetches a longword; top 8 bits read as zero.
// [R13] Advanced exception entry skips the extended register when invalid.
// [R14] Calls push the counter; exceptions push counter, flags, extended register.
// [R15] Register add and subtract take one state.
// [R16] Unsigned multiply takes 3 states byte-wise, 4 word-wise.
// [R17] Divide takes 12 states byte-wise, 20 word-wise.
// [R18] Signed multiply takes 4 states byte-wise, 5 word-wise.
// [R19] Instruction fetch forces the counter's lowest bit to zero.
// [R20] Mode pins are sampled at reset and held until next reset; here the mode is fixed advanced and o_mode_err follows the pins live.
`ifndef CPU_MODE_CONSTS_SVH
`define CPU_MODE_CONSTS_SVH
`define ADV_ADDR_W 24
`define SMALL_ADDR_W 16
`define SMALL_ADDR_MASK 24'h00_ffff
`define VEC_BASE 24'h00_0000
`define IND_AREA_LAST 24'h00_00ff
`define VEC_SHIFT_ADV 2
`define VEC_SHIFT_SMALL 1
`define ST_ADDSUB 5'h01
`define ST_MULU_B 5'h03
`define ST_MULU_W 5'h04
`define ST_MULS_B 5'h04
`define ST_MULS_W 5'h05
`define ST_DIV_B 5'h0c
`define ST_DIV_W 5'h14
`define MODE_PIN_ADV 2'h1
`endif

// ===== cpu_mode_pkg.sv
`default_nettype none
package cpu_mode_pkg;
   typedef enum logic [2:0] {
      OP_ADDSUB = 3'h0,
      OP_MULU_B = 3'h1,
      OP_MULU_W = 3'h2,
      OP_MULS_B = 3'h3,
      OP_MULS_W = 3'h4,
      OP_DIV_B = 3'h5,
      OP_DIV_W = 3'h6,
      OP_NONE = 3'h7
   } alu_op_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_BUSY = 2'h1
   } run_state_t;
   typedef struct packed {
      logic [31:0] wide_general_register;
      logic inc;
      logic dec;
      logic [2:0] step;
   } ptr_req_t;
   typedef struct packed {
      logic mode_adv;
      logic mode_valid;
      run_state_t state;
      logic [4:0] count;
      logic done;
      logic [31:0] ptr;
      logic [23:0] effective_address;
      logic [23:0] fetch_addr;
      logic [23:0] branch_target;
      logic [23:0] vec_addr;
      logic [2:0] push_mask;
   } core_state_t;
endpackage
`default_nettype wire
